// ==== verif/motion_irq_asserts.sv ====
`timescale 1ns/1ns
module motion_irq_asserts
  import motion_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [motion_irq_pkg::addr_width-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic auto_stop_event,
  input wire logic [3:0] excitation_phase_out,
  input wire logic [3:0] index_count,
  input wire logic [3:0] operating_state_code,
  input wire logic irq_n,
  input wire logic irq_output_mask,
  input wire logic [5:0] irq_enables,
  input wire logic [motion_irq_pkg::cause_width-1:0] irq_cause_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic st_rd;
  assign st_rd = read && !waitrequest && address == status_addr;

  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait longer than one cycle");
  a_irq_follow: assert property (1'b1 |=> irq_n ==
    !($past(|irq_cause_flags) && !$past(irq_output_mask))) else $error("irq line wrong");
  a_auto_set: assert property (auto_stop_event && irq_enables[0] |=> irq_cause_flags[7])
    else $error("auto stop flag not set");
  a_auto_cause: assert property ($rose(irq_cause_flags[7]) |->
    $past(auto_stop_event && irq_enables[0])) else $error("auto stop flag without cause");
  a_flag_clear: assert property (write && !waitrequest && address == cause_addr &&
    byteenable[0] && writedata[7] && !auto_stop_event |=> !irq_cause_flags[7])
    else $error("flag not cleared");
  a_status_irq: assert property (st_rd |-> readdata[31] == !$past(irq_n))
    else $error("status irq bit wrong");
  a_status_state: assert property (st_rd |-> readdata[27:24] == $past(operating_state_code))
    else $error("status state wrong");
  a_status_phase: assert property (st_rd |-> {readdata[11:8], readdata[3:0]} ==
    $past({index_count, excitation_phase_out})) else $error("status phase or count wrong");

  c_flag_set: cover property (auto_stop_event && irq_enables[0]);
  c_status_read: cover property (st_rd);
  c_masked: cover property (irq_output_mask && |irq_cause_flags);
endmodule

bind motion_irq_enable_status_bank motion_irq_asserts motion_irq_asserts_inst (.clk, .rstn,
  .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .auto_stop_event,
  .excitation_phase_out, .index_count, .operating_state_code, .irq_n, .irq_output_mask,
  .irq_enables, .irq_cause_flags);

// ==== verif/motion_irq_enable_status_bank_tb.sv ====
`timescale 1ns/1ns
module motion_irq_enable_status_bank_tb;
  import motion_irq_pkg::*;
  logic clk, rstn, read, write, waitrequest, irq_n, irq_output_mask, sd_clear, latch;
  logic [addr_width-1:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, p, q, s, e;
  logic [5:0] ev, irq_enables;
  logic [15:0] env2_low;
  logic [cause_width-1:0] irq_cause_flags;
  int bad_count, compares;
  int cause_bit [6] = '{7, 8, 9, 10, 5, 6};

  motion_irq_enable_status_bank motion_irq_enable_status_bank_inst (.clk, .rstn, .address,
    .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
    .auto_stop_event(ev[0]), .cmd_stop_event(ev[1]), .sync_start_event(ev[2]),
    .ramp_down_event(ev[3]), .encoder_err_event(ev[4]), .pulser_err_event(ev[5]),
    .excitation_phase_out(p[3:0]), .excitation_default(p[4]), .index_count(p[11:8]),
    .position_count_zero(p[16]), .slowdown_is_input(p[20]), .slowdown_latch_clear(sd_clear),
    .deviation_clear_out(p[23]), .operating_state_code(p[27:24]), .ramp_point_passed(p[28]),
    .ub_input(p[5]), .fh_input(p[6]), .encoder_index(p[7]), .encoder_a(p[13]),
    .encoder_b(p[12]), .pulser_a_or_plus_dir(p[15]), .pulser_b_or_minus_dir(p[14]),
    .neg_end_limit(p[17]), .pos_end_limit(p[18]), .slowdown_input(p[19]),
    .origin_input(p[21]), .in_position_input(p[22]), .sync_start_n(~p[29]),
    .stop_input(p[30]), .irq_n, .env2_low, .irq_output_mask, .irq_enables, .irq_cause_flags);

  motion_irq_host motion_irq_host_inst (.clk, .waitrequest, .readdata, .address, .read,
    .write, .byteenable, .writedata);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr(input logic [addr_width-1:0] a, input logic [31:0] d, input logic [3:0] be);
    motion_irq_host_inst.xfer(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [addr_width-1:0] a, input logic [31:0] exp);
    motion_irq_host_inst.xfer(1'b0, a, 32'h0, 4'hF, q);
    chk_word(q, exp);
  endtask

  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wrap_up;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic t_reset;
    rd(env2_addr, env2_reset);
    rd(cause_addr, 32'h0);
    rd(10'h3FC, 32'h0);
    chk_bit(irq_n, 1'b1);
  endtask

  task automatic t_env2;
    wr(env2_addr, 32'hFFFF_A5C3, 4'h7);
    rd(env2_addr, 32'h007F_A5C3);
    wr(env2_addr, 32'h0000_005A, 4'h1);
    rd(env2_addr, 32'h007F_A55A);
    chk_word({16'h0, env2_low}, 32'h0000_A55A);
    chk_word({25'h0, irq_enables, irq_output_mask}, 32'h7F);
    wr(10'h3FC, 32'hFFFF_FFFF, 4'hF);
    rd(10'h3FC, 32'h0);
    wr(env2_addr, 32'h007E_0000, 4'h7);
  endtask

  task automatic t_events;
    for (int i = 0; i < 6; i++)
    begin
      pulse(6'h01 << i);
      chk_word(32'(irq_cause_flags), 32'h1 << cause_bit[i]);
      chk_bit(irq_n, 1'b0);
      rd(status_addr, 32'h8000_0000);
      wr(cause_addr, ~(32'h1 << cause_bit[i]) & 32'h7E0, 4'h3);
      rd(cause_addr, 32'h1 << cause_bit[i]);
      wr(cause_addr, 32'h1 << cause_bit[i], 4'h3);
      rd(cause_addr, 32'h0);
      @(negedge clk);
      chk_bit(irq_n, 1'b1);
    end
  endtask

  task automatic t_mask;
    wr(env2_addr, 32'h0003_0000, 4'h7);
    pulse(6'h03);
    chk_word(32'(irq_cause_flags), 32'h080);
    chk_bit(irq_n, 1'b1);
    rd(status_addr, 32'h0);
    wr(env2_addr, 32'h0002_0000, 4'h7);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_bit(irq_n, 1'b0);
    wr(cause_addr, 32'h0000_07E0, 4'h3);
  endtask

  task automatic t_status;
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'hF};
    for (int k = 0; k < 8; k++)
    begin
      s = ((k[0] ? 32'h5AA5_5AA5 : 32'h255A_A55A) ^ {11'h0, k[1], 20'h0}) & 32'h70FF_FFFF
        | {4'h0, codes[k], 24'h0};
      @(posedge clk);
      p <= s;
      latch = latch | s[19];
      repeat (6) @(posedge clk);
      e = {1'b0, s[30:21], s[20] & s[19], latch, s[18:0]};
      rd(status_addr, e);
    end
    wr(status_addr, 32'hFFFF_FFFF, 4'hF);
    rd(status_addr, e);
    @(posedge clk);
    sd_clear <= 1'b1;
    @(posedge clk);
    sd_clear <= 1'b0;
    repeat (2) @(posedge clk);
    rd(status_addr, e & ~32'h0008_0000);
  endtask

  initial
  begin
    rstn = 1'b0;
    ev = 6'h00;
    p = 32'h0;
    sd_clear = 1'b0;
    latch = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_env2;
    t_events;
    t_mask;
    t_status;
    wrap_up;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up;
  end
endmodule

// ==== verif/motion_irq_host.sv ====
`timescale 1ns/1ns
module motion_irq_host
  import motion_irq_pkg::*;
(
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [motion_irq_pkg::addr_width-1:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata
);
  initial
  begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0;
  end

  // Request held until waitrequest is seen low; lines scrambled after release
  task automatic xfer(input logic w, input logic [addr_width-1:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    byteenable <= be;
    writedata <= (a == env2_addr) ? (d & 32'h007F_FFFF) : d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~writedata;
  endtask
endmodule

// ==== verilog/motion_irq_enable_status_bank.sv ====
`timescale 1ns/1ns
module motion_irq_enable_status_bank
  import motion_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [motion_irq_pkg::addr_width-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic auto_stop_event,
  input wire logic cmd_stop_event,
  input wire logic sync_start_event,
  input wire logic ramp_down_event,
  input wire logic encoder_err_event,
  input wire logic pulser_err_event,
  input wire logic [3:0] excitation_phase_out,
  input wire logic excitation_default,
  input wire logic [3:0] index_count,
  input wire logic position_count_zero,
  input wire logic slowdown_is_input,
  input wire logic slowdown_latch_clear,
  input wire logic deviation_clear_out,
  input wire logic [3:0] operating_state_code,
  input wire logic ramp_point_passed,
  input wire logic ub_input,
  input wire logic fh_input,
  input wire logic encoder_index,
  input wire logic encoder_a,
  input wire logic encoder_b,
  input wire logic pulser_a_or_plus_dir,
  input wire logic pulser_b_or_minus_dir,
  input wire logic neg_end_limit,
  input wire logic pos_end_limit,
  input wire logic slowdown_input,
  input wire logic origin_input,
  input wire logic in_position_input,
  input wire logic sync_start_n,
  input wire logic stop_input,
  output logic irq_n,
  output logic [motion_irq_pkg::env2_low_width-1:0] env2_low,
  output logic irq_output_mask,
  output logic [5:0] irq_enables,
  output logic [motion_irq_pkg::cause_width-1:0] irq_cause_flags
);
  import motion_irq_pkg::*;

  logic rst_meta;
  logic rst_sync;
  logic rst_n;

  bus_state_t bus_state;
  bus_state_t next_bus_state;
  logic req;
  logic accept;
  logic env2_write;
  logic cause_write;

  logic [31:0] env2;
  logic [cause_width-1:0] cause_set;
  logic [cause_width-1:0] cause_clear;

  logic [pin_count-1:0] pin_raw;
  logic [pin_count-1:0] pin_s1;
  logic [pin_count-1:0] pin_s2;
  logic [pin_count-1:0] pin_s3;
  logic [pin_count-1:0] pin_level;

  logic slowdown_latched;
  logic irq_pending;
  logic [31:0] status_word;
  logic [31:0] cause_word;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  // Pin order: sync start is inverted so a low terminal reads as on
  // UB and FH are terminals as well and get the same filtering
  assign pin_raw = {
    fh_input,
    ub_input,
    ~sync_start_n,
    stop_input,
    in_position_input,
    origin_input,
    slowdown_input,
    pos_end_limit,
    neg_end_limit,
    pulser_a_or_plus_dir,
    pulser_b_or_minus_dir,
    encoder_a,
    encoder_b,
    encoder_index
  };

  // Three stages; the filtered level moves once stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= pin_sync_reset;
      pin_s2 <= pin_sync_reset;
      pin_s3 <= pin_sync_reset;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_level <= pin_sync_reset;
    end
    else
    begin
      pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 | pin_s3));
    end
  end

  // Avalon-MM: every access answers in the cycle after it is seen
  assign req = read | write;
  assign waitrequest = req & (bus_state == bus_idle);
  assign accept = req & (bus_state == bus_answer);

  // Write strobes for the two writable registers
  assign env2_write = accept & write & (address == env2_addr);
  assign cause_write = accept & write & (address == cause_addr);

  always_comb
  begin
    next_bus_state = bus_state;
    case (bus_state)
      bus_idle:
      begin
        if (req)
        begin
          next_bus_state = bus_answer;
        end
      end
      bus_answer:
      begin
        next_bus_state = bus_idle;
      end
      default:
      begin
        next_bus_state = bus_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_state <= bus_idle;
    end
    else
    begin
      bus_state <= next_bus_state;
    end
  end

  // Environment register, bits above the enable field stay zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      env2 <= env2_reset;
    end
    else if (env2_write)
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (byteenable[b])
        begin
          env2[b*8 +: 8] <= writedata[b*8 +: 8];
        end
      end
      env2[31:env2_top_pos+1] <= '0;
    end
  end

  assign env2_low = env2[env2_low_width-1:0];
  assign irq_output_mask = env2[irq_output_mask_pos];
  assign irq_enables = env2[pulser_err_irq_en_pos:auto_stop_irq_en_pos];

  // Gated event sources
  always_comb
  begin
    cause_set = '0;
    cause_set[cause_auto_stop_pos] = auto_stop_event & env2[auto_stop_irq_en_pos];
    cause_set[cause_cmd_stop_pos] = cmd_stop_event & env2[cmd_stop_irq_en_pos];
    cause_set[cause_sync_start_pos] = sync_start_event & env2[sync_start_irq_en_pos];
    cause_set[cause_ramp_down_pos] = ramp_down_event & env2[ramp_down_irq_en_pos];
    cause_set[cause_encoder_err_pos] = encoder_err_event & env2[encoder_err_irq_en_pos];
    cause_set[cause_pulser_err_pos] = pulser_err_event & env2[pulser_err_irq_en_pos];
  end

  // Write-one-to-clear on the low two lanes
  always_comb
  begin
    cause_clear = '0;
    if (cause_write)
    begin
      if (byteenable[0])
      begin
        cause_clear[7:0] = writedata[7:0];
      end
      if (byteenable[1])
      begin
        cause_clear[cause_width-1:8] = writedata[cause_width-1:8];
      end
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_cause_flags <= cause_reset;
    end
    else
    begin
      irq_cause_flags <= (irq_cause_flags & ~cause_clear) | cause_set;
    end
  end

  assign irq_pending = |irq_cause_flags;

  // Flags keep updating under the mask; only the pin is held high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_n <= 1'b1;
    end
    else
    begin
      irq_n <= ~(irq_pending & ~env2[irq_output_mask_pos]);
    end
  end

  // Slow-down latch, held until the motion core clears it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slowdown_latched <= 1'b0;
    end
    else if (pin_level[7])
    begin
      slowdown_latched <= 1'b1;
    end
    else if (slowdown_latch_clear)
    begin
      slowdown_latched <= 1'b0;
    end
  end

  // Status word assembly
  always_comb
  begin
    status_word = '0;
    status_word[phase_monitor_pos +: 4] = excitation_phase_out;
    status_word[excitation_default_pos] = excitation_default;
    status_word[ub_level_pos] = pin_level[12];
    status_word[fh_level_pos] = pin_level[13];
    status_word[index_level_pos] = pin_level[0];
    status_word[index_count_pos +: 4] = index_count;
    status_word[encoder_b_pos] = pin_level[1];
    status_word[encoder_a_pos] = pin_level[2];
    status_word[pulser_b_pos] = pin_level[3];
    status_word[pulser_a_pos] = pin_level[4];
    status_word[position_zero_pos] = position_count_zero;
    status_word[neg_limit_pos] = pin_level[5];
    status_word[pos_limit_pos] = pin_level[6];
    status_word[slowdown_latched_pos] = slowdown_latched;
    status_word[slowdown_live_pos] = pin_level[7] & slowdown_is_input;
    status_word[origin_pos] = pin_level[8];
    status_word[in_position_pos] = pin_level[9];
    status_word[deviation_clear_pos] = deviation_clear_out;
    status_word[operating_state_pos +: 4] = operating_state_code;
    status_word[ramp_point_pos] = ramp_point_passed;
    status_word[sync_start_pos] = pin_level[11];
    status_word[stop_input_pos] = pin_level[10];
    status_word[irq_line_pos] = ~irq_n;
  end

  // Cause flags widened to a bus word
  always_comb
  begin
    cause_word = '0;
    cause_word[cause_width-1:0] = irq_cause_flags;
  end

  // Read data, captured while waitrequest is high; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readdata <= 32'h0000_0000;
    end
    else if (read && bus_state == bus_idle)
    begin
      if (address == env2_addr)
      begin
        readdata <= env2;
      end
      else if (address == status_addr)
      begin
        readdata <= status_word;
      end
      else if (address == cause_addr)
      begin
        readdata <= cause_word;
      end
      else
      begin
        readdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ==== verilog/motion_irq_pkg.sv ====
package motion_irq_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] env2_index = 8'h04;
  localparam logic [7:0] status_index = 8'h26;
  localparam logic [7:0] cause_index = 8'h2A;
  localparam int addr_width = 10;
  localparam logic [addr_width-1:0] env2_addr = {env2_index, 2'b00};
  localparam logic [addr_width-1:0] status_addr = {status_index, 2'b00};
  localparam logic [addr_width-1:0] cause_addr = {cause_index, 2'b00};

  // Second environment register fields
  localparam int env2_low_width = 16;
  localparam int irq_output_mask_pos = 16;
  localparam int auto_stop_irq_en_pos = 17;
  localparam int cmd_stop_irq_en_pos = 18;
  localparam int sync_start_irq_en_pos = 19;
  localparam int ramp_down_irq_en_pos = 20;
  localparam int encoder_err_irq_en_pos = 21;
  localparam int pulser_err_irq_en_pos = 22;
  localparam int env2_top_pos = 22;
  localparam logic [31:0] env2_reset = 32'h0000_0000;

  // Cause flag fields
  localparam int cause_encoder_err_pos = 5;
  localparam int cause_pulser_err_pos = 6;
  localparam int cause_auto_stop_pos = 7;
  localparam int cause_cmd_stop_pos = 8;
  localparam int cause_sync_start_pos = 9;
  localparam int cause_ramp_down_pos = 10;
  localparam int cause_width = 11;
  localparam logic [cause_width-1:0] cause_reset = 11'h000;

  // Status register fields
  localparam int phase_monitor_pos = 0;
  localparam int excitation_default_pos = 4;
  localparam int ub_level_pos = 5;
  localparam int fh_level_pos = 6;
  localparam int index_level_pos = 7;
  localparam int index_count_pos = 8;
  localparam int encoder_b_pos = 12;
  localparam int encoder_a_pos = 13;
  localparam int pulser_b_pos = 14;
  localparam int pulser_a_pos = 15;
  localparam int position_zero_pos = 16;
  localparam int neg_limit_pos = 17;
  localparam int pos_limit_pos = 18;
  localparam int slowdown_latched_pos = 19;
  localparam int slowdown_live_pos = 20;
  localparam int origin_pos = 21;
  localparam int in_position_pos = 22;
  localparam int deviation_clear_pos = 23;
  localparam int operating_state_pos = 24;
  localparam int ramp_point_pos = 28;
  localparam int sync_start_pos = 29;
  localparam int stop_input_pos = 30;
  localparam int irq_line_pos = 31;

  // Operating state codes
  localparam logic [3:0] op_stopped = 4'h0;
  localparam logic [3:0] op_wait_direction = 4'h1;
  localparam logic [3:0] op_wait_start = 4'h2;
  localparam logic [3:0] op_wait_pulser = 4'h3;
  localparam logic [3:0] op_dir_timer = 4'h4;
  localparam logic [3:0] op_clear_timer = 4'h5;
  localparam logic [3:0] op_low_speed = 4'h7;
  localparam logic [3:0] op_start_stop = 4'hF;

  localparam int pin_count = 14;
  localparam logic [pin_count-1:0] pin_sync_reset = 14'h0000;

  typedef enum logic [1:0] {
    bus_idle = 2'b01,
    bus_answer = 2'b10
  } bus_state_t;

endpackage
